// file: bgp_pkg.sv
package bgp_pkg;

    // Pin port geometry
    localparam int unsigned PIN_W  = 16;
    localparam int unsigned GRP_W  = 8;
    localparam int unsigned GRP_N  = 2;

    // Register offsets inside the 256-byte memory window
    localparam logic [7:0]  OFF_DRIVE  = 8'h0c;
    localparam logic [7:0]  OFF_SAMPLE = 8'h10;
    localparam logic [7:0]  OFF_CTRL   = 8'h14;
    localparam int unsigned WIN_LSB    = 8;

    // Control register fields
    localparam int unsigned CTRL_DIR_LO = 0;
    localparam int unsigned CTRL_DIR_HI = 1;
    localparam int unsigned CTRL_LAMP   = 31;

    // Reset values: groups released as inputs, nothing driven
    localparam logic [1:0]  DIR_RST   = 2'h3;
    localparam logic [15:0] DRIVE_RST = 16'h0000;
    localparam logic        LAMP_RST  = 1'b0;

    // Configuration header
    localparam logic [15:0] CLASS_CODE  = 16'h0780;
    localparam logic [7:0]  PROG_IF     = 8'h00;
    localparam logic [5:0]  CFG_ID      = 6'h00;
    localparam logic [5:0]  CFG_CMD     = 6'h01;
    localparam logic [5:0]  CFG_CLASS   = 6'h02;
    localparam logic [5:0]  CFG_BAR0    = 6'h04;
    localparam int unsigned CMD_MEM_EN  = 1;
    localparam logic [15:0] STATUS_RO   = 16'h0200;

    // Bus commands
    localparam logic [3:0] CMD_MRD  = 4'h6;
    localparam logic [3:0] CMD_MWR  = 4'h7;
    localparam logic [3:0] CMD_CRD  = 4'ha;
    localparam logic [3:0] CMD_CWR  = 4'hb;
    localparam logic [3:0] CMD_MRM  = 4'hc;
    localparam logic [3:0] CMD_MRL  = 4'he;
    localparam logic [3:0] CMD_MWI  = 4'hf;

    // Heartbeat half period
    localparam int unsigned HB_HALF_MS    = 250;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned HB_HALF_CYC   =
        HB_HALF_MS * 1000000 / CLK_PERIOD_NS;

    localparam int unsigned SEL_W = 2;
    localparam int unsigned SEL_N = 4;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CLAIM = 3'b001,
        ST_DATA  = 3'b010,
        ST_HOLD  = 3'b011,
        ST_TURN  = 3'b100
    } bgp_state_e;

endpackage

// file: bgp_pin_if.sv
`timescale 1ns/1ps
interface bgp_pin_if;
    logic [15:0] drive;
    logic [1:0]  dir_in;
    logic [15:0] sample;

    modport ctrl (output drive, output dir_in, input sample);
    modport bank (input drive, input dir_in, output sample);
endinterface

// file: bgp_pin_bank.sv
`timescale 1ns/1ps
module bgp_pin_bank (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_b_i,
    // Register side
    bgp_pin_if.bank                        pif,
    // Header pins
    input  wire logic [bgp_pkg::PIN_W-1:0] pins_i,
    output logic      [bgp_pkg::PIN_W-1:0] pins_o,
    output logic      [bgp_pkg::PIN_W-1:0] pins_oe_b_o
);
    import bgp_pkg::*;

    logic [PIN_W-1:0] sample_reg;
    logic [PIN_W-1:0] sample_next;

    for (genvar g = 0; g < GRP_N; g++) begin : g_grp
        // Direction 1 releases the drivers, 0 drives the group
        assign pins_oe_b_o[g*GRP_W +: GRP_W] = {GRP_W{pif.dir_in[g]}};
        assign pins_o[g*GRP_W +: GRP_W] = pif.drive[g*GRP_W +: GRP_W];
        // Output pins sample as zero
        assign sample_next[g*GRP_W +: GRP_W] =
            pins_i[g*GRP_W +: GRP_W] & {GRP_W{pif.dir_in[g]}};
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sample_reg <= '0;
        end else begin
            sample_reg <= sample_next;
        end
    end

    assign pif.sample = sample_reg;
endmodule

// file: bgp_gpio_port.sv
// What this block does
// - Drive value register at 0x0C; bits 15:0 set pin levels, upper reserved.
// - Sample register at 0x10; bits 15:0 report pin levels, upper reserved.
// - Register bit n maps to port pin n in both registers.
// - Control at 0x14: bit 0 directs pins 0-7, bit 1 pins 8-15.
// - Direction 0 drives the group from drive register; 1 releases it.
// - Control bit 31 directly drives the user indicator lamp.
// - Heartbeat indicator toggles continuously while the logic runs.
// - Stack selector setting modulo four picks interrupt, clock, IDSEL set.
// - Configuration header reports class code 0x0780.
// - Configuration header returns fixed vendor and device identity codes.
// - Sample register answers 16-bit word reads with all sixteen pins.
// - Sample bits of pins set as outputs read zero.
// - Registers live in the 256-byte first memory base address window.
`timescale 1ns/1ps
module bgp_gpio_port #(
    parameter logic [15:0]  VENDOR_ID   = 16'h1a5e, // Arbitrary value
    parameter logic [15:0]  DEVICE_ID   = 16'h0b07, // Arbitrary value
    parameter logic [7:0]   REV_ID      = 8'h01,    // Arbitrary value
    parameter int unsigned  HB_HALF     = bgp_pkg::HB_HALF_CYC
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_b_i,
    // Bus address/data and control
    input  wire logic [31:0]               ad_i,
    output logic      [31:0]               ad_o,
    output logic                           ad_oe_b_o,
    input  wire logic [3:0]                cbe_n_i,
    input  wire logic                      frame_n_i,
    input  wire logic                      irdy_n_i,
    output logic                           par_o,
    output logic                           par_oe_b_o,
    output logic                           trdy_n_o,
    output logic                           devsel_n_o,
    output logic                           stop_n_o,
    output logic                           tgt_oe_b_o,
    input  wire logic [bgp_pkg::SEL_N-1:0] idsel_i,
    // Stack position
    input  wire logic [3:0]                stack_rotary_selector_i,
    output logic      [bgp_pkg::SEL_N-1:0] stack_line_sel_o,
    // Header pins
    input  wire logic [bgp_pkg::PIN_W-1:0] pins_i,
    output logic      [bgp_pkg::PIN_W-1:0] pins_o,
    output logic      [bgp_pkg::PIN_W-1:0] pins_oe_b_o,
    // Indicators
    output logic                           heartbeat_indicator_o,
    output logic                           user_indicator_lamp_o
);
    import bgp_pkg::*;

    bgp_pin_if pif ();

    bgp_state_e       state_reg,  state_next;
    logic             frame_q_reg, frame_q_next;
    logic             cfg_reg,    cfg_next;
    logic             rd_reg,     rd_next;
    logic [7:0]       addr_reg,   addr_next;
    logic [31:0]      rdata_reg,  rdata_next;
    logic             par_reg,    par_next;
    logic             pdrv_reg,   pdrv_next;
    logic [15:0]      drive_reg,  drive_next;
    logic [1:0]       dir_reg,    dir_next;
    logic             lamp_reg,   lamp_next;
    logic             memen_reg,  memen_next;
    logic [23:0]      bar_reg,    bar_next;
    logic [SEL_W-1:0] sel_reg,    sel_next;
    logic             cap_reg,    cap_next;
    logic [31:0]      hb_cnt_reg, hb_cnt_next;
    logic             hb_reg,     hb_next;

    logic       addr_phase;
    logic       idsel_hit;
    logic       cfg_cmd;
    logic       mem_cmd;
    logic       mem_rd;
    logic [5:0] cfg_idx;
    logic [31:0] rd_mux;

    assign addr_phase = !frame_n_i && frame_q_reg;
    assign idsel_hit  = idsel_i[sel_reg];
    assign cfg_cmd    = (cbe_n_i == CMD_CRD) || (cbe_n_i == CMD_CWR);
    assign mem_rd     = (cbe_n_i == CMD_MRD) || (cbe_n_i == CMD_MRM) ||
                        (cbe_n_i == CMD_MRL);
    assign mem_cmd    = mem_rd || (cbe_n_i == CMD_MWR) ||
                        (cbe_n_i == CMD_MWI);
    assign cfg_idx    = addr_reg[7:2];

    // Read data for the latched address
    always_comb begin
        rd_mux = '0;
        if (cfg_reg) begin
            case (cfg_idx)
                CFG_ID:    rd_mux = {DEVICE_ID, VENDOR_ID};
                CFG_CMD:   rd_mux = {STATUS_RO, 14'h0000, memen_reg, 1'b0};
                CFG_CLASS: rd_mux = {CLASS_CODE, PROG_IF, REV_ID};
                CFG_BAR0:  rd_mux = {bar_reg, 8'h00};
                default:   rd_mux = '0;
            endcase
        end else begin
            case (addr_reg)
                OFF_DRIVE:  rd_mux = {16'h0000, drive_reg};
                OFF_SAMPLE: rd_mux = {16'h0000, pif.sample};
                OFF_CTRL:   rd_mux = {lamp_reg, 29'h0, dir_reg};
                default:    rd_mux = '0;
            endcase
        end
    end

    // Bus target sequencing and register writes
    always_comb begin
        state_next   = state_reg;
        frame_q_next = frame_n_i;
        cfg_next     = cfg_reg;
        rd_next      = rd_reg;
        addr_next    = addr_reg;
        rdata_next   = rdata_reg;
        par_next     = par_reg;
        pdrv_next    = 1'b0;
        drive_next   = drive_reg;
        dir_next     = dir_reg;
        lamp_next    = lamp_reg;
        memen_next   = memen_reg;
        bar_next     = bar_reg;
        case (state_reg)
            ST_IDLE: begin
                if (addr_phase && cfg_cmd && idsel_hit &&
                    ad_i[1:0] == 2'b00) begin
                    state_next = ST_CLAIM;
                    cfg_next   = 1'b1;
                    rd_next    = (cbe_n_i == CMD_CRD);
                    addr_next  = ad_i[7:0];
                end else if (addr_phase && mem_cmd && memen_reg &&
                             ad_i[31:WIN_LSB] == bar_reg) begin
                    state_next = ST_CLAIM;
                    cfg_next   = 1'b0;
                    rd_next    = mem_rd;
                    addr_next  = {ad_i[7:2], 2'b00};
                end
            end
            ST_CLAIM: begin
                // Turnaround cycle before the target may drive data
                rdata_next = rd_mux;
                state_next = ST_DATA;
            end
            ST_DATA: begin
                if (!irdy_n_i) begin
                    state_next = frame_n_i ? ST_TURN : ST_HOLD;
                    par_next   = ^{rdata_reg, cbe_n_i};
                    pdrv_next  = rd_reg;
                    if (!rd_reg && cfg_reg) begin
                        if (cfg_idx == CFG_CMD && !cbe_n_i[0]) begin
                            memen_next = ad_i[CMD_MEM_EN];
                        end
                        if (cfg_idx == CFG_BAR0) begin
                            for (int b = 1; b < 4; b++) begin
                                if (!cbe_n_i[b]) begin
                                    bar_next[(b-1)*8 +: 8] = ad_i[b*8 +: 8];
                                end
                            end
                        end
                    end else if (!rd_reg) begin
                        if (addr_reg == OFF_DRIVE) begin
                            if (!cbe_n_i[0]) drive_next[7:0]  = ad_i[7:0];
                            if (!cbe_n_i[1]) drive_next[15:8] = ad_i[15:8];
                        end
                        if (addr_reg == OFF_CTRL) begin
                            if (!cbe_n_i[0]) begin
                                dir_next = {ad_i[CTRL_DIR_HI],
                                            ad_i[CTRL_DIR_LO]};
                            end
                            if (!cbe_n_i[3]) lamp_next = ad_i[CTRL_LAMP];
                        end
                    end
                end
            end
            ST_HOLD: begin
                // Master wanted a burst: hold the disconnect until it ends
                if (frame_n_i) state_next = ST_TURN;
            end
            ST_TURN: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Stack position captured once after reset; residues pick one set
    always_comb begin
        sel_next = sel_reg;
        cap_next = 1'b1;
        if (!cap_reg) sel_next = stack_rotary_selector_i[SEL_W-1:0];
    end

    // Heartbeat keeps toggling as long as the clock runs
    always_comb begin
        hb_cnt_next = hb_cnt_reg + 32'h1;
        hb_next     = hb_reg;
        if (hb_cnt_reg >= HB_HALF - 1) begin
            hb_cnt_next = '0;
            hb_next     = !hb_reg;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg   <= ST_IDLE;
            frame_q_reg <= 1'b1;
            cfg_reg     <= 1'b0;
            rd_reg      <= 1'b0;
            addr_reg    <= '0;
            rdata_reg   <= '0;
            par_reg     <= 1'b0;
            pdrv_reg    <= 1'b0;
            drive_reg   <= DRIVE_RST;
            dir_reg     <= DIR_RST;
            lamp_reg    <= LAMP_RST;
            memen_reg   <= 1'b0;
            bar_reg     <= '0;
            sel_reg     <= '0;
            cap_reg     <= 1'b0;
            hb_cnt_reg  <= '0;
            hb_reg      <= 1'b0;
        end else begin
            state_reg   <= state_next;
            frame_q_reg <= frame_q_next;
            cfg_reg     <= cfg_next;
            rd_reg      <= rd_next;
            addr_reg    <= addr_next;
            rdata_reg   <= rdata_next;
            par_reg     <= par_next;
            pdrv_reg    <= pdrv_next;
            drive_reg   <= drive_next;
            dir_reg     <= dir_next;
            lamp_reg    <= lamp_next;
            memen_reg   <= memen_next;
            bar_reg     <= bar_next;
            sel_reg     <= sel_next;
            cap_reg     <= cap_next;
            hb_cnt_reg  <= hb_cnt_next;
            hb_reg      <= hb_next;
        end
    end

    // Target handshake; TURN drives them high once before release
    assign tgt_oe_b_o = (state_reg == ST_IDLE);
    assign devsel_n_o = !(state_reg == ST_CLAIM || state_reg == ST_DATA ||
                          state_reg == ST_HOLD);
    assign trdy_n_o   = (state_reg != ST_DATA);
    // Only single data phases: a burst is disconnected with data
    assign stop_n_o   = !((state_reg == ST_DATA && !frame_n_i) ||
                          state_reg == ST_HOLD);
    assign ad_o       = rdata_reg;
    assign ad_oe_b_o  = !(state_reg == ST_DATA && rd_reg);
    assign par_o      = par_reg;
    assign par_oe_b_o = !pdrv_reg;

    for (genvar s = 0; s < SEL_N; s++) begin : g_sel
        assign stack_line_sel_o[s] = cap_reg && (sel_reg == s);
    end

    assign pif.drive = drive_reg;
    assign pif.dir_in = dir_reg;
    assign heartbeat_indicator_o = hb_reg;
    assign user_indicator_lamp_o = lamp_reg;

    bgp_pin_bank u_bank (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .pif         (pif.bank),
        .pins_i      (pins_i),
        .pins_o      (pins_o),
        .pins_oe_b_o (pins_oe_b_o)
    );
endmodule

// file: bgp_pin_partner.sv
`timescale 1ns/1ps
module bgp_pin_partner (
    // Far-side signal levels
    input  wire logic [bgp_pkg::PIN_W-1:0] ext_i,
    // Port drive seen at the header
    input  wire logic [bgp_pkg::PIN_W-1:0] drive_i,
    input  wire logic [bgp_pkg::PIN_W-1:0] drive_oe_b_i,
    // Resolved header levels
    output logic      [bgp_pkg::PIN_W-1:0] level_o
);
    import bgp_pkg::*;
    // The outside stays high impedance on driven pins, so they read back
    // the port's own level; released pins carry the external signal
    always_comb begin
        for (int i = 0; i < PIN_W; i++) begin
            level_o[i] = drive_oe_b_i[i] ? ext_i[i] : drive_i[i];
        end
    end
endmodule

// file: bgp_gpio_port_chk.sv
`timescale 1ns/1ps
module bgp_gpio_port_chk #(
    parameter int unsigned HB_HALF = 4
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_b_i,
    // Bus
    input  wire logic [31:0]               ad_i,
    input  wire logic [31:0]               ad_o,
    input  wire logic [3:0]                cbe_n_i,
    input  wire logic                      frame_n_i,
    input  wire logic                      irdy_n_i,
    input  wire logic                      trdy_n_o,
    input  wire logic                      devsel_n_o,
    // Stack position
    input  wire logic [3:0]                stack_rotary_selector_i,
    input  wire logic [bgp_pkg::SEL_N-1:0] stack_line_sel_o,
    // Pins and indicators
    input  wire logic [bgp_pkg::PIN_W-1:0] pins_o,
    input  wire logic [bgp_pkg::PIN_W-1:0] pins_oe_b_o,
    input  wire logic                      heartbeat_indicator_o,
    input  wire logic                      user_indicator_lamp_o
);
    import bgp_pkg::*;
    logic        frame_reg, frame_next, hb_reg, hb_next;
    logic [7:0]  off_reg, off_next;
    logic [3:0]  cmd_reg, cmd_next;
    logic [31:0] cnt_reg, cnt_next;
    logic        xfer, wr, rd, chg;
    assign xfer = !devsel_n_o && !trdy_n_o && !irdy_n_i;
    assign wr   = cmd_reg == CMD_MWR || cmd_reg == CMD_MWI;
    assign rd   = cmd_reg inside {CMD_MRD, CMD_MRM, CMD_MRL};
    assign chg  = heartbeat_indicator_o != hb_reg;
    always_comb begin
        frame_next = frame_n_i;
        hb_next    = heartbeat_indicator_o;
        off_next   = off_reg;
        cmd_next   = cmd_reg;
        cnt_next   = chg ? 32'h1 : cnt_reg + 32'h1;
        if (!frame_n_i && frame_reg) begin
            off_next = ad_i[7:0];
            cmd_next = cbe_n_i;
        end
    end
    // Count starts at one so the first toggle may land on either edge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_reg <= 1'b1;
            hb_reg    <= 1'b0;
            off_reg   <= 8'h00;
            cmd_reg   <= 4'h0;
            cnt_reg   <= 32'h1;
        end else begin
            frame_reg <= frame_next;
            hb_reg    <= hb_next;
            off_reg   <= off_next;
            cmd_reg   <= cmd_next;
            cnt_reg   <= cnt_next;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_drive_write: assert property (xfer && wr && off_reg == OFF_DRIVE
        && cbe_n_i[1:0] == 2'h0 |=> pins_o == $past(ad_i[15:0]))
        else $error("drive pins differ from written value");
    a_dir_write: assert property (xfer && wr && off_reg == OFF_CTRL
        && !cbe_n_i[0] |=> pins_oe_b_o ==
        {{8{$past(ad_i[1])}}, {8{$past(ad_i[0])}}})
        else $error("pin enables differ from direction bits");
    a_lamp_write: assert property (xfer && wr && off_reg == OFF_CTRL
        && !cbe_n_i[3] |=> user_indicator_lamp_o == $past(ad_i[31]))
        else $error("lamp differs from control bit");
    a_sample_read: assert property (xfer && rd && off_reg == OFF_SAMPLE
        |-> ad_o[31:16] == 16'h0 && (ad_o[15:0] & ~pins_oe_b_o) == 16'h0)
        else $error("sample shows output pins or reserved bits");
    a_devsel_medium: assert property ($fell(devsel_n_o)
        |-> $past(frame_n_i, 2) && !$past(frame_n_i))
        else $error("select not one cycle after address");
    a_trdy_next: assert property ($fell(devsel_n_o) |=> !trdy_n_o)
        else $error("ready not one cycle after select");
    a_stack_onehot: assert property (stack_line_sel_o != 4'h0
        |-> stack_line_sel_o == 4'h1 << stack_rotary_selector_i[1:0])
        else $error("stack line selection wrong");
    a_reset_state: assert property ($rose(rst_b_i) |-> pins_oe_b_o ==
        16'hffff && pins_o == 16'h0 && !user_indicator_lamp_o)
        else $error("port not idle after reset");
    a_hb_period: assert property (chg
        |-> cnt_reg >= HB_HALF && cnt_reg <= HB_HALF + 1)
        else $error("heartbeat toggled early");
    a_hb_alive: assert property (cnt_reg <= HB_HALF + 1)
        else $error("heartbeat stuck");
endmodule
bind bgp_gpio_port bgp_gpio_port_chk #(.HB_HALF(HB_HALF)) chk (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ad_i(ad_i), .ad_o(ad_o),
    .cbe_n_i(cbe_n_i), .frame_n_i(frame_n_i), .irdy_n_i(irdy_n_i),
    .trdy_n_o(trdy_n_o), .devsel_n_o(devsel_n_o),
    .stack_rotary_selector_i(stack_rotary_selector_i),
    .stack_line_sel_o(stack_line_sel_o), .pins_o(pins_o),
    .pins_oe_b_o(pins_oe_b_o), .heartbeat_indicator_o(heartbeat_indicator_o),
    .user_indicator_lamp_o(user_indicator_lamp_o));

// file: test_bgp_gpio_port.sv
`timescale 1ns/1ps
module test_bgp_gpio_port;
    import bgp_pkg::*;
    localparam logic [15:0] VID = 16'h5a3c; // Arbitrary value
    localparam logic [15:0] DID = 16'h0d41; // Arbitrary value
    localparam logic [7:0]  REV = 8'h07;    // Arbitrary value
    localparam logic [31:0] BAR = 32'h40001000;
    localparam int          DLY = 5;
    typedef struct packed {
        logic [3:0]  cmd;
        logic [7:0]  off;
        logic [3:0]  be_n;
        logic [31:0] wd;
        logic [31:0] exp;
    } bgp_row_s;
    bgp_row_s    rows [17] = '{
        '{CMD_CWR, 8'h10, 4'h0, BAR, 32'h0},
        '{CMD_CWR, 8'h04, 4'h0, 32'h2, 32'h0},
        '{CMD_CRD, 8'h00, 4'h0, 32'h0, {DID, VID}},
        '{CMD_CRD, 8'h08, 4'h0, 32'h0, {16'h0780, 8'h00, REV}},
        '{CMD_CRD, 8'h10, 4'h0, 32'h0, BAR},
        '{CMD_MWR, 8'h14, 4'h0, 32'hfffffffc, 32'h0},
        '{CMD_MWR, 8'h0c, 4'h0, 32'hffffa55a, 32'h0},
        '{CMD_MRD, 8'h0c, 4'h0, 32'h0, 32'h0000a55a},
        '{CMD_MRM, 8'h10, 4'h0, 32'h0, 32'h0},
        '{CMD_MRL, 8'h14, 4'h0, 32'h0, 32'h80000000},
        '{CMD_MWI, 8'h14, 4'h0, 32'hfffffffd, 32'h0},
        '{CMD_MRD, 8'h10, 4'hc, 32'h0, 32'h00000096},
        '{CMD_MWR, 8'h14, 4'h0, 32'h00000003, 32'h0},
        '{CMD_MRD, 8'h10, 4'h0, 32'h0, 32'h00003c96},
        '{CMD_MRD, 8'h1c, 4'h0, 32'h0, 32'h0},
        '{CMD_MWR, 8'h0c, 4'he, 32'h0000ffff, 32'h0},
        '{CMD_MRD, 8'h0c, 4'h0, 32'h0, 32'h0000a5ff}};
    logic        clk_i, rst_b_i, frame_n, irdy_n, trdy_n, devsel_n;
    logic        hit, hb, ad_oe_b, lamp, par, par_oe_b, stop_n, tgt_oe_b;
    logic        pe;
    logic [1:0]  pc;
    logic [31:0] ad_m, ad_w, ad_o, rd;
    logic [3:0]  cbe_n, idsel, strap, sel;
    logic [15:0] pins_i, pins_o, pins_oe_b;
    int          failures, cmp_count, cyc, n;
    assign ad_w = ad_oe_b ? ad_m : ad_o;
    bgp_gpio_port #(.VENDOR_ID(VID), .DEVICE_ID(DID), .REV_ID(REV),
                    .HB_HALF(4)) uut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .ad_i(ad_w), .ad_o(ad_o),
        .ad_oe_b_o(ad_oe_b), .cbe_n_i(cbe_n), .frame_n_i(frame_n),
        .irdy_n_i(irdy_n), .par_o(par), .par_oe_b_o(par_oe_b),
        .trdy_n_o(trdy_n), .idsel_i(idsel),
        .devsel_n_o(devsel_n), .stop_n_o(stop_n), .tgt_oe_b_o(tgt_oe_b),
        .stack_rotary_selector_i(strap), .stack_line_sel_o(sel),
        .pins_i(pins_i), .pins_o(pins_o), .pins_oe_b_o(pins_oe_b),
        .heartbeat_indicator_o(hb), .user_indicator_lamp_o(lamp));
    bgp_pin_partner pins (.ext_i(16'h3c96), .drive_i(pins_o),
        .drive_oe_b_i(pins_oe_b), .level_o(pins_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Odd command codes are writes; the master gives up after six cycles
    task automatic bus(input logic [3:0] cmd, input logic [31:0] a,
                       input logic [3:0] be, input logic [31:0] wd);
        @(posedge clk_i);
        #DLY;
        frame_n = 1'b0;
        ad_m = a;
        cbe_n = cmd;
        @(posedge clk_i);
        #DLY;
        frame_n = 1'b1;
        irdy_n = 1'b0;
        cbe_n = be;
        ad_m = cmd[0] ? wd : ~a;
        n = 0;
        while (trdy_n !== 1'b0 && n < 6) begin
            @(posedge clk_i);
            #DLY;
            n++;
        end
        hit = devsel_n === 1'b0 && tgt_oe_b === 1'b0 && stop_n === 1'b1;
        rd = ad_w;
        @(posedge clk_i);
        #DLY;
        pc = {par_oe_b, par};
        irdy_n = 1'b1;
        cbe_n = 4'hf;
        ad_m = ~ad_m;
        repeat (2) @(posedge clk_i);
        #DLY;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        rst_b_i = 1'b0;
        {frame_n, irdy_n, cbe_n, ad_m, idsel, strap} = {6'h3f, 32'h0, 8'h46};
        {failures, cmp_count, cyc} = '0;
        repeat (20) @(posedge clk_i);
        #DLY;
        chk({pins_oe_b, pins_o}, 32'hffff0000);
        rst_b_i = 1'b1;
        repeat (2) @(posedge clk_i);
        foreach (rows[i]) begin
            bus(rows[i].cmd, (rows[i].cmd[3:1] == 3'b101) ? {24'h0, rows[i].off}
                : {BAR[31:8], rows[i].off}, rows[i].be_n, rows[i].wd);
            chk({31'h0, hit}, 32'h1);
            chk({31'h0, pc[1]}, {31'h0, rows[i].cmd[0]});
            if (!rows[i].cmd[0]) begin
                chk(rd, rows[i].exp);
                pe = ^{rows[i].exp, rows[i].be_n};
                chk({30'h0, pc}, {31'h0, pe});
            end
        end
        idsel = 4'b0001;
        bus(CMD_CRD, 32'h0, 4'h0, 32'h0);
        chk({31'h0, hit}, 32'h0);
        idsel = 4'b0100;
        bus(CMD_MRD, 32'h50001010, 4'h0, 32'h0);
        chk({31'h0, hit}, 32'h0);
        bus(CMD_MWR, BAR | 32'h14, 4'h0, 32'h80000002);
        chk({pins_oe_b, pins_o}, 32'hff00a5ff);
        chk({31'h0, lamp}, 32'h1);
        // Burst read is cut after one data phase
        @(posedge clk_i);
        #DLY;
        frame_n = 1'b0;
        ad_m = BAR | 32'h0c;
        cbe_n = CMD_MRD;
        @(posedge clk_i);
        #DLY;
        irdy_n = 1'b0;
        cbe_n = 4'h0;
        ad_m = ~ad_m;
        @(posedge clk_i);
        #DLY;
        chk({30'h0, stop_n, trdy_n}, 32'h0);
        chk(ad_w, 32'h0000a5ff);
        @(posedge clk_i);
        #DLY;
        chk({30'h0, stop_n, trdy_n}, 32'h1);
        frame_n = 1'b1;
        @(posedge clk_i);
        #DLY;
        irdy_n = 1'b1;
        cbe_n = 4'hf;
        repeat (2) @(posedge clk_i);
        #DLY;
        n = 0;
        repeat (40) begin
            hit = hb;
            @(posedge clk_i);
            #DLY;
            if (hb !== hit) n++;
        end
        chk(n, 32'd10);
        for (int s = 0; s < 16; s++) begin
            rst_b_i = 1'b0;
            strap = 4'(s);
            @(posedge clk_i);
            #DLY;
            chk({pins_oe_b, pins_o}, 32'hffff0000);
            chk({27'h0, lamp, sel}, 32'h0);
            rst_b_i = 1'b1;
            repeat (2) @(posedge clk_i);
            #DLY;
            chk({28'h0, sel}, 32'h1 << s[1:0]);
        end
        conclude();
    end
endmodule
